// *** dssf_char_rx.sv ***
// Serial character receiver with selectable parity and stop bits.
module dssf_char_rx
   import dssf_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic rxd,
   input wire logic [15:0] baud_div,
   input wire logic [1:0] framing,
   output logic [7:0] char_data,
   output logic char_valid,
   output logic par_err,
   output logic frm_err
);
   // ---------------------------------------------------------------
   // Bit timing and shift state
   // ---------------------------------------------------------------
   dssf_rx_t state_q;
   logic [15:0] tick_q;
   logic [2:0] bit_q;
   logic [7:0] shift_q;
   logic par_q;
   logic stop2_q;
   logic half_tick;
   logic full_tick;
   logic use_par;
   logic par_bad;

   assign half_tick = (tick_q == {1'b0, baud_div[15:1]});
   // One bit lasts exactly baud_div cycles, so the count ends one short of it.
   assign full_tick = (tick_q == baud_div - 16'h0001);
   assign use_par = (framing == FRM_EVEN_1) || (framing == FRM_ODD_1);
   // Odd framing wants an odd count of ones over data and parity bit.
   assign par_bad = (^shift_q ^ par_q) != (framing == FRM_ODD_1);

   // Character state machine; samples every bit in its middle.
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= DSSF_IDLE;
         tick_q <= 16'h0000;
         bit_q <= 3'h0;
         shift_q <= 8'h00;
         par_q <= 1'b0;
         stop2_q <= 1'b0;
         char_data <= 8'h00;
         char_valid <= 1'b0;
         par_err <= 1'b0;
         frm_err <= 1'b0;
      end else begin
         char_valid <= 1'b0;
         par_err <= 1'b0;
         frm_err <= 1'b0;
         tick_q <= tick_q + 16'h0001;
         case (state_q)
            DSSF_IDLE: begin
               tick_q <= 16'h0000;
               if (!rxd) begin
                  state_q <= DSSF_START;
               end
            end
            DSSF_START: begin
               if (half_tick) begin
                  tick_q <= 16'h0000;
                  bit_q <= 3'h0;
                  // A start bit that is gone by mid-bit was a glitch.
                  state_q <= rxd ? DSSF_IDLE : DSSF_DATA;
               end
            end
            DSSF_DATA: begin
               if (full_tick) begin
                  tick_q <= 16'h0000;
                  shift_q <= {rxd, shift_q[7:1]};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     stop2_q <= (framing == FRM_NONE_2);
                     state_q <= use_par ? DSSF_PAR : DSSF_STOP;
                  end
               end
            end
            DSSF_PAR: begin
               if (full_tick) begin
                  tick_q <= 16'h0000;
                  par_q <= rxd;
                  state_q <= DSSF_STOP;
               end
            end
            DSSF_STOP: begin
               if (full_tick) begin
                  tick_q <= 16'h0000;
                  if (!rxd) begin
                     frm_err <= 1'b1;
                     state_q <= DSSF_IDLE;
                  end else if (stop2_q) begin
                     stop2_q <= 1'b0;
                  end else begin
                     state_q <= DSSF_IDLE;
                     // Bad parity drops the character, which then fails the check.
                     if (use_par && par_bad) begin
                        par_err <= 1'b1;
                     end else begin
                        char_data <= shift_q;
                        char_valid <= 1'b1;
                     end
                  end
               end
            end
            default: state_q <= DSSF_IDLE;
         endcase
      end
   end
endmodule

// *** dssf_checker_sva.sv ***
// Port checker of the serial slave framing block.
module dssf_checker
   import dssf_pkg::*;
#(
   parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic rxd,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic msg_valid,
   input wire logic modbus_active,
   input wire logic link_lost
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------
   // Shadow state and assertions
   // ----------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [1:0] frm_q;
   int unsigned idle_q;
   int unsigned quiet_q;
   // Framing shadow; a read must return the last code written.
   always_ff @(posedge clk) begin
      if (reset) frm_q <= FRM_NONE_1;
      else if (reg_wr && reg_addr == REG_FRAMING) frm_q <= reg_wdata[1:0];
   end
   // Line silence since the last low level, longer than the design's own count.
   always_ff @(posedge clk) begin
      if (reset || !rxd) idle_q <= 0;
      else idle_q <= idle_q + 1;
   end
   // Modbus time since the last good message; paused when another protocol runs.
   always_ff @(posedge clk) begin
      if (reset || msg_valid) quiet_q <= 0;
      else if (modbus_active) quiet_q <= quiet_q + 1;
   end
   sequence s_proto(logic [1:0] v);
      reg_wr && reg_addr == REG_PROTO && reg_wdata[1:0] == v;
   endsequence
   a_proto_on: assert property (s_proto(PROTO_MODBUS) |=> modbus_active)
      else $error("protocol code 3 did not enable the modbus path");
   a_proto_off: assert property (s_proto(PROTO_NATIVE) |=> !modbus_active)
      else $error("protocol code 0 left the modbus path on");
   a_proto_keep: assert property (s_proto(2'h2) |=> $stable(modbus_active))
      else $error("unused protocol code changed the mode");
   a_frm_read: assert property (reg_rd && reg_addr == REG_FRAMING |=>
      reg_rdata == {14'h0, frm_q}) else $error("framing code read back wrong");
   a_valid_pulse: assert property (msg_valid |=> !msg_valid)
      else $error("message pulse longer than one cycle");
   a_valid_gap: assert property (msg_valid |->
      idle_q >= (GAP_MIN_MS - 1) * CYC_PER_MS_P) else $error("message ended without silence");
   a_valid_active: assert property (msg_valid |-> modbus_active)
      else $error("message accepted outside modbus mode");
   a_lost_early: assert property ($rose(link_lost) |->
      quiet_q >= (LOSS_MIN_S * MS_PER_S - 1) * CYC_PER_MS_P) else $error("link lost too early");
   a_lost_clear: assert property (msg_valid |-> ##[0:2] !link_lost)
      else $error("good message did not clear link loss");
endmodule
bind dssf_top dssf_checker #(.CYC_PER_MS_P(CYC_PER_MS_P)) dssf_checker_inst (.clk, .reset,
   .rxd, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .msg_valid, .modbus_active,
   .link_lost);

// *** dssf_master_model.sv ***
// Bus master model that sends framed characters and checked messages on the line.
module dssf_master_model
   import dssf_pkg::*;
#(
   parameter int unsigned BIT_CYC = 16
)
(
   input wire logic clk,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------
   // Senders
   // ----------
   // The line idles high between characters, as a pulled-up bus does.
   initial rxd = 1'b1;
   task automatic hold(input logic v);
      rxd <= v;
      repeat (BIT_CYC) @(posedge clk);
   endtask
   // One character, framed as the bench asks; a mismatch is a commanded fault.
   task automatic send_byte(input logic [7:0] b, input logic [1:0] frm);
      @(posedge clk);
      hold(1'b0);
      for (int i = 0; i < 8; i++) hold(b[i]);
      if (frm == FRM_EVEN_1) hold(^b);
      if (frm == FRM_ODD_1) hold(~^b);
      hold(1'b1);
      if (frm == FRM_NONE_2) hold(1'b1);
   endtask
   // Payload then check word; a pause before byte brk mimics a slow master.
   task automatic send_msg(input int n, input logic [1:0] frm, input logic bad,
                           input int brk, input int pause);
      logic [15:0] crc;
      logic [7:0] b;
      crc = CRC_INIT;
      for (int i = 0; i < n; i++) begin
         b = 8'h21 + 8'h13 * i[7:0];
         if (i == brk) repeat (pause) @(posedge clk);
         send_byte(b, frm);
         crc ^= {8'h0, b};
         for (int k = 0; k < 8; k++) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
      end
      if (bad) crc = ~crc;
      send_byte(crc[7:0], frm);
      send_byte(crc[15:8], frm);
   endtask
endmodule

// *** dssf_pkg.sv ***
// Package with the constants, register map and types of the serial slave framing block.
package dssf_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned GAP_MIN_MS = 10;
   localparam int unsigned GAP_MAX_MS = 2000;
   localparam int unsigned GAP_DEF_MS = 100;
   localparam int unsigned LOSS_MIN_S = 1;
   localparam int unsigned LOSS_MAX_S = 99;
   localparam int unsigned LOSS_DEF_S = 1;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned BAUD_DIV_DEF = 347;
   // ---------------------------------------------------------------
   // Register map (word offsets on the plain register port)
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_PROTO = 4'h0;
   localparam logic [3:0] REG_FRAMING = 4'h1;
   localparam logic [3:0] REG_GAP_MS = 4'h2;
   localparam logic [3:0] REG_LOSS_S = 4'h3;
   localparam logic [3:0] REG_BAUD_DIV = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h5;
   localparam logic [3:0] REG_GOOD_CNT = 4'h6;
   localparam logic [3:0] REG_BAD_CNT = 4'h7;
   localparam logic [3:0] REG_MSG_LEN = 4'h8;
   // Status bit positions.
   localparam int unsigned ST_LOST = 0;
   localparam int unsigned ST_ACTIVE = 1;
   localparam int unsigned ST_PAR_ERR = 2;
   localparam int unsigned ST_FRM_ERR = 3;
   // ---------------------------------------------------------------
   // Reset values and encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] PROTO_NATIVE = 2'h0;
   localparam logic [1:0] PROTO_BLDG = 2'h1;
   localparam logic [1:0] PROTO_MODBUS = 2'h3;
   localparam logic [1:0] FRM_EVEN_1 = 2'h0;
   localparam logic [1:0] FRM_ODD_1 = 2'h1;
   localparam logic [1:0] FRM_NONE_1 = 2'h2;
   localparam logic [1:0] FRM_NONE_2 = 2'h3;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   typedef enum logic [2:0] {DSSF_IDLE, DSSF_START, DSSF_DATA, DSSF_PAR, DSSF_STOP} dssf_rx_t;
endpackage

// *** dssf_top.sv ***
// Modbus serial slave framing: char receive, gap timeout, CRC check, link loss supervision.
//
// Overview of operation
// - A two-bit framing code selects even/1, odd/1, none/1 (default) or none/2 stop bits.
// - The inter-character timeout is programmable from 10 to 2000 ms and defaults to 100 ms.
// - When the timeout expires with no new character, the bytes so far form one message.
// - Every message is CRC checked and a failing one is dropped silently, with no reply.
// - About 100 ms usually suffices, 35 ms works on some nets, and long values delay replies.
// - A gap between telegrams beyond 1 to 99 s (default 1 s) declares the link lost.
module dssf_top
   import dssf_pkg::*;
#(
   parameter int unsigned CYC_PER_MS_P = CYC_PER_MS,
   parameter int unsigned MAX_LEN = 256
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic rxd,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic msg_valid,
   output logic [7:0] msg_rd_data,
   input wire logic [7:0] msg_rd_addr,
   output logic modbus_active,
   output logic link_lost
);
   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [1:0] proto_q;
   logic [1:0] framing_q;
   logic [10:0] gap_ms_q;
   logic [6:0] loss_s_q;
   logic [15:0] baud_div_q;

   // Software writes; out-of-range times are clamped to the legal span.
   always_ff @(posedge clk) begin
      if (reset) begin
         proto_q <= PROTO_NATIVE;
         framing_q <= FRM_NONE_1;
         gap_ms_q <= 11'(GAP_DEF_MS);
         loss_s_q <= 7'(LOSS_DEF_S);
         baud_div_q <= 16'(BAUD_DIV_DEF);
      end else if (reg_wr) begin
         case (reg_addr)
            REG_PROTO: begin
               // Code 2 is not a protocol; it is ignored.
               if (reg_wdata[1:0] != 2'h2) proto_q <= reg_wdata[1:0];
            end
            REG_FRAMING: framing_q <= reg_wdata[1:0];
            REG_GAP_MS: begin
               if (reg_wdata < 16'(GAP_MIN_MS)) gap_ms_q <= 11'(GAP_MIN_MS);
               else if (reg_wdata > 16'(GAP_MAX_MS)) gap_ms_q <= 11'(GAP_MAX_MS);
               else gap_ms_q <= reg_wdata[10:0];
            end
            REG_LOSS_S: begin
               if (reg_wdata < 16'(LOSS_MIN_S)) loss_s_q <= 7'(LOSS_MIN_S);
               else if (reg_wdata > 16'(LOSS_MAX_S)) loss_s_q <= 7'(LOSS_MAX_S);
               else loss_s_q <= reg_wdata[6:0];
            end
            REG_BAUD_DIV: baud_div_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   assign modbus_active = (proto_q == PROTO_MODBUS);

   // ---------------------------------------------------------------
   // Character receiver
   // ---------------------------------------------------------------
   logic [7:0] ch_data;
   logic ch_valid;
   logic ch_par_err;
   logic ch_frm_err;

   dssf_char_rx u_rx (
      .clk(clk),
      .reset(reset),
      .rxd(rxd),
      .baud_div(baud_div_q),
      .framing(framing_q),
      .char_data(ch_data),
      .char_valid(ch_valid),
      .par_err(ch_par_err),
      .frm_err(ch_frm_err)
   );

   logic ch_take;
   logic ch_bad;
   assign ch_take = ch_valid && modbus_active;
   assign ch_bad = (ch_par_err || ch_frm_err) && modbus_active;

   // ---------------------------------------------------------------
   // Millisecond enable and gap timer
   // ---------------------------------------------------------------
   logic [31:0] ms_div_q;
   logic ms_tick;
   logic [10:0] gap_cnt_q;
   logic in_msg_q;
   logic gap_done;

   // One-cycle enable every millisecond drives the slow timers.
   always_ff @(posedge clk) begin
      if (reset || ms_tick) ms_div_q <= 32'h0000_0000;
      else ms_div_q <= ms_div_q + 32'h0000_0001;
   end
   assign ms_tick = (ms_div_q == 32'(CYC_PER_MS_P - 1));

   // Gap counter restarts on every character, good or bad.
   always_ff @(posedge clk) begin
      if (reset || ch_take || ch_bad) gap_cnt_q <= 11'h000;
      else if (in_msg_q && ms_tick) gap_cnt_q <= gap_cnt_q + 11'h001;
   end
   // The gap is measured in whole ms ticks, so it may be up to one ms short.
   assign gap_done = in_msg_q && ms_tick && (gap_cnt_q + 11'h001 >= gap_ms_q);

   // ---------------------------------------------------------------
   // Message buffer and CRC
   // ---------------------------------------------------------------
   logic [7:0] buf_mem [MAX_LEN];
   logic [8:0] len_q;
   logic [15:0] crc_q;
   logic [15:0] crc_d;
   logic bad_q;

   // Bytewise reflected CRC-16; the check field itself folds in to zero.
   always_comb begin
      crc_d = crc_q ^ {8'h00, ch_data};
      for (int i = 0; i < 8; i++) begin
         crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
      end
   end

   always_ff @(posedge clk) begin
      if (ch_take && (len_q < 9'(MAX_LEN))) buf_mem[len_q[7:0]] <= ch_data;
   end

   // Collects one message; the gap timeout closes it.
   always_ff @(posedge clk) begin
      if (reset || gap_done) begin
         in_msg_q <= 1'b0;
         len_q <= 9'h000;
         crc_q <= CRC_INIT;
         bad_q <= 1'b0;
      end else begin
         if (ch_take || ch_bad) in_msg_q <= 1'b1;
         if (ch_take) begin
            crc_q <= crc_d;
            if (len_q < 9'(MAX_LEN)) len_q <= len_q + 9'h001;
            else bad_q <= 1'b1;
         end
         if (ch_bad) bad_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Message verdict, counters and link supervision
   // ---------------------------------------------------------------
   logic good_msg;
   logic [15:0] good_cnt_q;
   logic [15:0] bad_cnt_q;
   logic [8:0] msg_len_q;
   logic [16:0] loss_cnt_q;
   logic par_seen_q;
   logic frm_seen_q;

   // A valid frame holds an address, a function and two check bytes at least.
   assign good_msg = gap_done && !bad_q && (crc_q == 16'h0000) && (len_q >= 9'h004);

   always_ff @(posedge clk) begin
      if (reset) begin
         msg_valid <= 1'b0;
         msg_len_q <= 9'h000;
         good_cnt_q <= 16'h0000;
         bad_cnt_q <= 16'h0000;
      end else begin
         // Failing frames raise no pulse; the bad counter counts each of them.
         msg_valid <= good_msg;
         if (good_msg) begin
            msg_len_q <= len_q - 9'h002;
            good_cnt_q <= good_cnt_q + 16'h0001;
         end else if (gap_done) begin
            bad_cnt_q <= bad_cnt_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) msg_rd_data <= 8'h00;
      else msg_rd_data <= buf_mem[msg_rd_addr];
   end

   // Telegram supervision counts ms since the last good message.
   always_ff @(posedge clk) begin
      if (reset || good_msg || !modbus_active) begin
         loss_cnt_q <= 17'h00000;
         link_lost <= 1'b0;
      end else if (ms_tick && !link_lost) begin
         loss_cnt_q <= loss_cnt_q + 17'h00001;
         if (loss_cnt_q + 17'h00001 >= 17'(loss_s_q * MS_PER_S)) link_lost <= 1'b1;
      end
   end

   // Sticky error flags, cleared by a status read; a new error wins.
   always_ff @(posedge clk) begin
      if (reset) begin
         par_seen_q <= 1'b0;
         frm_seen_q <= 1'b0;
      end else begin
         if (ch_par_err) par_seen_q <= 1'b1;
         else if (reg_rd && reg_addr == REG_STATUS) par_seen_q <= 1'b0;
         if (ch_frm_err) frm_seen_q <= 1'b1;
         else if (reg_rd && reg_addr == REG_STATUS) frm_seen_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Register read port, data one cycle after the strobe
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_PROTO: reg_rdata <= {14'h0000, proto_q};
            REG_FRAMING: reg_rdata <= {14'h0000, framing_q};
            REG_GAP_MS: reg_rdata <= {5'h00, gap_ms_q};
            REG_LOSS_S: reg_rdata <= {9'h000, loss_s_q};
            REG_BAUD_DIV: reg_rdata <= baud_div_q;
            REG_STATUS: reg_rdata <= {12'h000, frm_seen_q, par_seen_q, in_msg_q, link_lost};
            REG_GOOD_CNT: reg_rdata <= good_cnt_q;
            REG_BAD_CNT: reg_rdata <= bad_cnt_q;
            REG_MSG_LEN: reg_rdata <= {7'h00, msg_len_q};
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule

// *** dssf_top_bench.sv ***
// Self-checking bench of the serial slave framing block.
module dssf_top_bench
   import dssf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------
   // Harness
   // ----------
   localparam int unsigned CPM = 40;
   localparam int LIMIT = 95000;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic rxd;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic msg_valid;
   logic [7:0] msg_rd_data;
   logic [7:0] msg_rd_addr = 8'h0;
   logic modbus_active;
   logic link_lost;
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [15:0] exp_good = 16'h0;
   logic [15:0] exp_bad = 16'h0;
   logic [15:0] d;
   logic s;
   // Rows: write flag, address, write data, value read back.
   localparam logic [36:0] ROWS [14] = '{
      {1'b0, REG_PROTO, 16'h0, 16'h0}, {1'b0, REG_FRAMING, 16'h0, 16'h2},
      {1'b0, REG_GAP_MS, 16'h0, 16'h64}, {1'b0, REG_LOSS_S, 16'h0, 16'h1},
      {1'b1, REG_PROTO, 16'h1, 16'h1}, {1'b1, REG_PROTO, 16'h2, 16'h1},
      {1'b1, REG_PROTO, 16'h3, 16'h3}, {1'b1, REG_GAP_MS, 16'h9, 16'ha},
      {1'b1, REG_GAP_MS, 16'h7d1, 16'h7d0}, {1'b1, REG_GAP_MS, 16'ha, 16'ha},
      {1'b1, REG_LOSS_S, 16'h0, 16'h1}, {1'b1, REG_LOSS_S, 16'h64, 16'h63},
      {1'b1, REG_LOSS_S, 16'h1, 16'h1}, {1'b1, REG_BAUD_DIV, 16'h10, 16'h10}};
   dssf_top #(.CYC_PER_MS_P(CPM)) dssf_top_inst (.clk, .reset, .rxd, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .msg_valid, .msg_rd_data, .msg_rd_addr, .modbus_active,
      .link_lost);
   dssf_master_model #(.BIT_CYC(16)) dssf_master_model_inst (.clk, .rxd);
   // Free-running 40 MHz clock.
   initial begin
      forever #12.5 clk = ~clk;
   end
   // A hang is cut short here and still reaches the closing report.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
   endtask
   // Waits at most 20 ms for a message pulse; a bad message must stay silent throughout.
   task automatic wait_msg(output logic p);
      p = 1'b0;
      for (int k = 0; k < 20 * CPM && p !== 1'b1; k++) begin
         @(negedge clk);
         p = msg_valid;
      end
   endtask
   // ----------
   // Sequence
   // ----------
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      foreach (ROWS[i]) begin
         if (ROWS[i][36]) wr(ROWS[i][35:32], ROWS[i][31:16]);
         rd(ROWS[i][35:32], d);
         cmp("register", ROWS[i][15:0], d);
      end
      for (int f = 0; f < 4; f++) begin
         wr(REG_FRAMING, {14'h0, f[1:0]});
         dssf_master_model_inst.send_msg(6, f[1:0], 1'b0, 99, 0);
         wait_msg(s);
         cmp("good message", 16'h1, {15'h0, s});
         exp_good++;
      end
      rd(REG_MSG_LEN, d);
      cmp("message length", 16'h6, d);
      @(posedge clk);
      msg_rd_addr <= 8'h1;
      repeat (2) @(negedge clk);
      cmp("buffer byte", 16'h34, {8'h0, msg_rd_data});
      dssf_master_model_inst.send_msg(6, FRM_NONE_2, 1'b1, 99, 0);
      wait_msg(s);
      cmp("bad check dropped", 16'h0, {15'h0, s});
      exp_bad++;
      wr(REG_FRAMING, {14'h0, FRM_EVEN_1});
      dssf_master_model_inst.send_msg(6, FRM_ODD_1, 1'b0, 99, 0);
      wait_msg(s);
      cmp("parity fault dropped", 16'h0, {15'h0, s});
      exp_bad++;
      rd(REG_STATUS, d);
      cmp("parity flag", 16'h1, {15'h0, d[ST_PAR_ERR]});
      dssf_master_model_inst.send_msg(6, FRM_EVEN_1, 1'b0, 3, 5 * CPM);
      wait_msg(s);
      cmp("short pause joined", 16'h1, {15'h0, s});
      exp_good++;
      dssf_master_model_inst.send_msg(6, FRM_EVEN_1, 1'b0, 3, 15 * CPM);
      wait_msg(s);
      cmp("long pause split", 16'h0, {15'h0, s});
      exp_bad += 2;
      wr(REG_PROTO, {14'h0, PROTO_NATIVE});
      dssf_master_model_inst.send_msg(6, FRM_EVEN_1, 1'b0, 99, 0);
      wait_msg(s);
      cmp("native mode ignores", 16'h0, {15'h0, s});
      wr(REG_PROTO, {14'h0, PROTO_MODBUS});
      rd(REG_GOOD_CNT, d);
      cmp("good count", exp_good, d);
      rd(REG_BAD_CNT, d);
      cmp("bad count", exp_bad, d);
      // The loss limit is 1 s, that is 40000 cycles at the shortened millisecond.
      dssf_master_model_inst.send_msg(4, FRM_EVEN_1, 1'b0, 99, 0);
      wait_msg(s);
      repeat (39000) @(negedge clk);
      cmp("link kept", 16'h0, {15'h0, link_lost});
      for (int k = 0; k < 2000 && link_lost !== 1'b1; k++) @(negedge clk);
      cmp("link lost", 16'h1, {15'h0, link_lost});
      dssf_master_model_inst.send_msg(4, FRM_EVEN_1, 1'b0, 99, 0);
      wait_msg(s);
      repeat (3) @(negedge clk);
      cmp("link regained", 16'h0, {15'h0, link_lost});
      @(posedge clk);
      reset <= 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      cmp("mode after reset", 16'h0, {15'h0, modbus_active});
      rd(REG_FRAMING, d);
      cmp("framing after reset", 16'h2, d);
      rd(REG_GAP_MS, d);
      cmp("gap after reset", 16'h64, d);
      give_verdict();
   end
endmodule
